//--- core/power_up_preset_loader.v
// power-up preset selection, preset save/list commands and dual-channel setup
`timescale 1ns/100ps
`include "preset_consts.vh"
module power_up_preset_loader #(
    parameter PIN_BITS = `DEF_PIN_BITS,
    parameter PIN_MAP  = `DEF_PIN_MAP
) (
    input  wire                I_CLK_SYS,
    input  wire                I_RESET,
    input  wire [5:0]          I_PRESET_PIN,
    input  wire                I_CMD_VALID,
    input  wire [3:0]          I_CMD_CODE,
    input  wire                I_CMD_HAS_ARG,
    input  wire [`FREQ_W-1:0]  I_CMD_ARG,
    input  wire [`NAME_W-1:0]  I_CMD_NAME,
    output reg                 O_CMD_READY,
    output reg                 O_RUN,
    output reg  [3:0]          O_SELECTION,
    output reg  [1:0]          O_CHAN_SEL,
    output reg  [`FREQ_W-1:0]  O_FREQ_CH1,
    output reg  [`FREQ_W-1:0]  O_FREQ_CH2,
    output reg  [3:0]          O_MOD_CH1,
    output reg  [3:0]          O_MOD_CH2,
    output reg                 O_LDPC_CH1,
    output reg                 O_LDPC_CH2,
    output reg                 O_STC,
    output reg                 O_RANDOMIZER,
    output reg                 O_INVERT,
    output reg                 O_DIFF_ENC,
    output reg                 O_RSP_VALID,
    output reg  [2:0]          O_RSP_KIND,
    output reg  [3:0]          O_RSP_INDEX,
    output reg                 O_RSP_USED,
    output reg  [`NAME_W-1:0]  O_RSP_NAME,
    output reg  [`CFG_W-1:0]   O_RSP_CONFIG,
    output reg  [2:0]          O_RSP_PIN,
    output reg                 O_RSP_LAST
);
    // ==================================================================
    // states
    localparam [3:0] ST_SAMPLE = 4'b0001;
    localparam [3:0] ST_LOAD   = 4'b0010;
    localparam [3:0] ST_RUN    = 4'b0100;
    localparam [3:0] ST_LIST   = 4'b1000;
    localparam [3:0] LAST_PIN_BIT = PIN_BITS - 1;

    reg  [3:0]         state_q;
    reg  [3:0]         idx_q;
    reg  [3:0]         end_q;
    reg  [2:0]         kind_q;
    reg                wr_en_q;
    reg  [3:0]         wr_idx_q;
    reg  [`NAME_W-1:0] wr_name_q;
    wire [3:0]         strap_sel;
    wire               strap_done;
    wire [`CFG_W-1:0]  rd_cfg;
    wire [`NAME_W-1:0] rd_name;
    wire               rd_used;
    wire [`CFG_W-1:0]  live_cfg;
    wire               cmd_take;
    wire [3:0]         arg4;
    wire               arg_slot;

    // ==================================================================
    // helpers
    function hits;
        input [1:0] chan;
        input [1:0] target;
        begin
            hits = (chan == target) || (chan == `CHAN_BOTH);
        end
    endfunction

    function [2:0] pin_of;
        input [3:0] bitno;
        begin
            pin_of = PIN_MAP[3*bitno +: 3];
        end
    endfunction

    assign cmd_take = I_CMD_VALID && O_CMD_READY;
    assign arg4     = I_CMD_ARG[3:0];
    assign arg_slot = I_CMD_HAS_ARG && (I_CMD_ARG[`FREQ_W-1:4] == 12'h000) && (arg4 != 4'h0);

    // live setup packed the way a preset stores it
    assign live_cfg = {O_DIFF_ENC, O_INVERT, O_RANDOMIZER, O_LDPC_CH2, O_LDPC_CH1,
                       O_MOD_CH2, O_MOD_CH1, O_FREQ_CH2, O_FREQ_CH1};

    // ==================================================================
    // sub-blocks
    strap_sampler #(
        .PIN_BITS (PIN_BITS),
        .PIN_MAP  (PIN_MAP)
    ) u_strap (
        .i_clk    (I_CLK_SYS),
        .i_reset  (I_RESET),
        .i_pins   (I_PRESET_PIN),
        .o_sel    (strap_sel),
        .o_done   (strap_done)
    );

    preset_store #(
        .CFG_W     (`CFG_W),
        .NAME_W    (`NAME_W),
        .DEPTH     (`NUM_PRESETS)
    ) u_store (
        .i_clk     (I_CLK_SYS),
        .i_reset   (I_RESET),
        .i_wr_en   (wr_en_q),
        .i_wr_idx  (wr_idx_q),
        .i_wr_cfg  (live_cfg),
        .i_wr_name (wr_name_q),
        .i_rd_idx  (idx_q),
        .o_rd_cfg  (rd_cfg),
        .o_rd_name (rd_name),
        .o_rd_used (rd_used)
    );

    // ==================================================================
    // control
    always @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            state_q      <= ST_SAMPLE;
            idx_q        <= 4'h0;
            end_q        <= 4'h0;
            kind_q       <= 3'h0;
            wr_en_q      <= 1'b0;
            wr_idx_q     <= 4'h0;
            wr_name_q    <= {`NAME_W{1'b0}};
            O_CMD_READY  <= 1'b0;
            O_RUN        <= 1'b0;
            O_SELECTION  <= 4'h0;
            O_CHAN_SEL   <= `CHAN_ONE;
            O_FREQ_CH1   <= `DEF_FREQ;
            O_FREQ_CH2   <= `DEF_FREQ;
            O_MOD_CH1    <= `DEF_MOD;
            O_MOD_CH2    <= `DEF_MOD;
            O_LDPC_CH1   <= 1'b0;
            O_LDPC_CH2   <= 1'b0;
            O_STC        <= 1'b0;
            O_RANDOMIZER <= 1'b0;
            O_INVERT     <= 1'b0;
            O_DIFF_ENC   <= 1'b0;
            O_RSP_VALID  <= 1'b0;
            O_RSP_KIND   <= 3'h0;
            O_RSP_INDEX  <= 4'h0;
            O_RSP_USED   <= 1'b0;
            O_RSP_NAME   <= {`NAME_W{1'b0}};
            O_RSP_CONFIG <= {`CFG_W{1'b0}};
            O_RSP_PIN    <= 3'h0;
            O_RSP_LAST   <= 1'b0;
        end else begin
            wr_en_q     <= 1'b0;
            O_RSP_VALID <= 1'b0;
            O_RSP_LAST  <= 1'b0;
            O_STC       <= (O_MOD_CH1 == `MOD_SOQPSK_STC) && (O_MOD_CH2 == `MOD_SOQPSK_STC);
            case (state_q)
                ST_SAMPLE: begin
                    if (strap_done) begin
                        O_SELECTION <= strap_sel;
                        idx_q       <= strap_sel;
                        if (strap_sel == 4'h0) begin
                            O_RUN       <= 1'b1;
                            O_CMD_READY <= 1'b1;
                            state_q     <= ST_RUN;
                        end else begin
                            state_q <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    O_FREQ_CH1   <= rd_cfg[`FREQ1_LSB +: `FREQ_W];
                    O_FREQ_CH2   <= rd_cfg[`FREQ2_LSB +: `FREQ_W];
                    O_MOD_CH1    <= rd_cfg[`MOD1_LSB +: 4];
                    O_MOD_CH2    <= rd_cfg[`MOD2_LSB +: 4];
                    O_LDPC_CH1   <= rd_cfg[`LDPC1_BIT];
                    O_LDPC_CH2   <= rd_cfg[`LDPC2_BIT];
                    O_RANDOMIZER <= rd_cfg[`RND_BIT];
                    O_INVERT     <= rd_cfg[`INV_BIT];
                    O_DIFF_ENC   <= rd_cfg[`DE_BIT];
                    O_RUN        <= 1'b1;
                    O_CMD_READY  <= 1'b1;
                    state_q      <= ST_RUN;
                end
                ST_RUN: begin
                    if (cmd_take) begin
                        O_RSP_VALID <= 1'b1;
                        O_RSP_LAST  <= 1'b1;
                        O_RSP_KIND  <= `RSP_ACK;
                        O_RSP_INDEX <= arg4;
                        if (I_CMD_CODE == `CMD_CHAN) begin
                            if (I_CMD_HAS_ARG && I_CMD_ARG >= 16'h0001 && I_CMD_ARG <= 16'h0003)
                                O_CHAN_SEL <= I_CMD_ARG[1:0];
                            else
                                O_RSP_KIND <= `RSP_ERR;
                        end else if (I_CMD_CODE == `CMD_MOD) begin
                            if (arg_slot) begin
                                if (hits(O_CHAN_SEL, `CHAN_ONE))
                                    O_MOD_CH1 <= arg4;
                                if (hits(O_CHAN_SEL, `CHAN_TWO))
                                    O_MOD_CH2 <= arg4;
                            end else begin
                                O_RSP_KIND <= `RSP_ERR;
                            end
                        end else if (I_CMD_CODE == `CMD_LDPC) begin
                            if (I_CMD_HAS_ARG && I_CMD_ARG[`FREQ_W-1:1] == 15'h0000) begin
                                if (hits(O_CHAN_SEL, `CHAN_ONE))
                                    O_LDPC_CH1 <= I_CMD_ARG[0];
                                if (hits(O_CHAN_SEL, `CHAN_TWO))
                                    O_LDPC_CH2 <= I_CMD_ARG[0];
                            end else begin
                                O_RSP_KIND <= `RSP_ERR;
                            end
                        end else if (I_CMD_CODE == `CMD_FREQ) begin
                            if (!I_CMD_HAS_ARG) begin
                                O_RSP_KIND <= `RSP_ERR;
                            end else if (O_STC) begin
                                // space-time coding needs both carriers identical
                                O_FREQ_CH1 <= I_CMD_ARG;
                                O_FREQ_CH2 <= I_CMD_ARG;
                            end else begin
                                if (hits(O_CHAN_SEL, `CHAN_ONE))
                                    O_FREQ_CH1 <= I_CMD_ARG;
                                if (hits(O_CHAN_SEL, `CHAN_TWO))
                                    O_FREQ_CH2 <= I_CMD_ARG;
                            end
                        end else if (I_CMD_CODE == `CMD_FLAGS) begin
                            if (I_CMD_HAS_ARG) begin
                                O_RANDOMIZER <= I_CMD_ARG[0];
                                O_INVERT     <= I_CMD_ARG[1];
                                O_DIFF_ENC   <= I_CMD_ARG[2];
                            end else begin
                                O_RSP_KIND <= `RSP_ERR;
                            end
                        end else if (I_CMD_CODE == `CMD_SAVE) begin
                            if (arg_slot) begin
                                wr_en_q    <= 1'b1;
                                wr_idx_q   <= arg4;
                                wr_name_q  <= I_CMD_NAME;
                                O_RSP_KIND <= `RSP_SAVED;
                            end else if (!I_CMD_HAS_ARG) begin
                                O_RSP_VALID <= 1'b0;
                                O_RSP_LAST  <= 1'b0;
                                O_CMD_READY <= 1'b0;
                                kind_q      <= `RSP_STATE;
                                idx_q       <= 4'h1;
                                end_q       <= 4'hf;
                                state_q     <= ST_LIST;
                            end else begin
                                O_RSP_KIND <= `RSP_ERR;
                            end
                        end else if (I_CMD_CODE == `CMD_LIST) begin
                            O_RSP_VALID <= 1'b0;
                            O_RSP_LAST  <= 1'b0;
                            O_CMD_READY <= 1'b0;
                            state_q     <= ST_LIST;
                            if (arg_slot) begin
                                kind_q <= `RSP_SETTINGS;
                                idx_q  <= arg4;
                                end_q  <= arg4;
                            end else begin
                                kind_q <= `RSP_NAME;
                                idx_q  <= 4'h1;
                                end_q  <= 4'hf;
                            end
                        end else if (I_CMD_CODE == `CMD_PINMAP) begin
                            O_RSP_VALID <= 1'b0;
                            O_RSP_LAST  <= 1'b0;
                            O_CMD_READY <= 1'b0;
                            kind_q      <= `RSP_PINMAP;
                            idx_q       <= 4'h0;
                            end_q       <= LAST_PIN_BIT;
                            state_q     <= ST_LIST;
                        end else begin
                            O_RSP_KIND <= `RSP_ERR;
                        end
                    end
                end
                ST_LIST: begin
                    // one response per cycle, the store is read combinationally
                    O_RSP_VALID  <= 1'b1;
                    O_RSP_KIND   <= kind_q;
                    O_RSP_INDEX  <= idx_q;
                    O_RSP_USED   <= rd_used;
                    O_RSP_NAME   <= rd_name;
                    O_RSP_CONFIG <= (kind_q == `RSP_SETTINGS) ? rd_cfg : {`CFG_W{1'b0}};
                    O_RSP_PIN    <= (kind_q == `RSP_PINMAP) ? pin_of(idx_q) : 3'h0;
                    if (idx_q == end_q) begin
                        O_RSP_LAST  <= 1'b1;
                        O_CMD_READY <= 1'b1;
                        state_q     <= ST_RUN;
                    end else begin
                        idx_q <= idx_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_SAMPLE;
                end
            endcase
        end
    end
endmodule // power_up_preset_loader

//--- core/preset_consts.vh
// constants for the power-up preset loader
// Overview of operation
// - at most four strap pins act as preset bits; pin-to-bit map is an option
// - an open pin (pulled up) reads as 0, a grounded pin reads as 1
// - all selection bits zero gives the normal, non-preset configuration
// - a nonzero selection picks preset 1..15 equal to the binary pin value
// - a preset holds frequency, modulation, randomizer, inversion, differential encoding
// - the pins are sampled once after each reset; later changes are ignored
// - save with a number stores the live setup; without one reports every preset
// - list shows all preset names, or every setting of one numbered preset
// - pin-map query reports which pins are selection bits and their weights
// - channel value 3 makes later setup commands apply to both channels
// - modulation 1 is plain SOQPSK, 13 adds space-time coding; LDPC 1 on, 0 off
// - without space-time coding each channel's frequency is set on its own
`ifndef PRESET_CONSTS_VH
`define PRESET_CONSTS_VH

// ==================================================================
// timing
`define CLK_PERIOD_NS   10
`define PIN_SETTLE_NS   200
`define PIN_SETTLE_CYC  ((`PIN_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==================================================================
// configuration word layout
`define FREQ_W          16
`define FREQ1_LSB       0
`define FREQ2_LSB       16
`define MOD1_LSB        32
`define MOD2_LSB        36
`define LDPC1_BIT       40
`define LDPC2_BIT       41
`define RND_BIT         42
`define INV_BIT         43
`define DE_BIT          44
`define CFG_W           45
`define NAME_W          32
`define NUM_PRESETS     16

// ==================================================================
// reset values
`define DEF_FREQ        16'h0900
`define DEF_MOD         4'h1
`define DEF_CFG         {3'h0, 2'h0, `DEF_MOD, `DEF_MOD, `DEF_FREQ, `DEF_FREQ}
`define DEF_PIN_MAP     12'h688
`define DEF_PIN_BITS    4

// ==================================================================
// command and argument codes
`define CMD_CHAN        4'h1
`define CMD_MOD         4'h2
`define CMD_LDPC        4'h3
`define CMD_FREQ        4'h4
`define CMD_SAVE        4'h5
`define CMD_LIST        4'h6
`define CMD_PINMAP      4'h7
`define CMD_FLAGS       4'h8
`define CHAN_ONE        2'h1
`define CHAN_TWO        2'h2
`define CHAN_BOTH       2'h3
`define MOD_SOQPSK      4'h1
`define MOD_SOQPSK_STC  4'hd

// ==================================================================
// response kinds
`define RSP_ACK         3'h1
`define RSP_ERR         3'h2
`define RSP_SAVED       3'h3
`define RSP_STATE       3'h4
`define RSP_NAME        3'h5
`define RSP_SETTINGS    3'h6
`define RSP_PINMAP      3'h7

`endif

//--- core/preset_store.v
// flip-flop storage for fifteen presets, slot zero unused
`timescale 1ns/100ps
`include "preset_consts.vh"
module preset_store #(
    parameter CFG_W  = `CFG_W,
    parameter NAME_W = `NAME_W,
    parameter DEPTH  = `NUM_PRESETS
) (
    input  wire              i_clk,
    input  wire              i_reset,
    input  wire              i_wr_en,
    input  wire [3:0]        i_wr_idx,
    input  wire [CFG_W-1:0]  i_wr_cfg,
    input  wire [NAME_W-1:0] i_wr_name,
    input  wire [3:0]        i_rd_idx,
    output wire [CFG_W-1:0]  o_rd_cfg,
    output wire [NAME_W-1:0] o_rd_name,
    output wire              o_rd_used
);
    reg [CFG_W-1:0]  cfg_q  [0:DEPTH-1];
    reg [NAME_W-1:0] name_q [0:DEPTH-1];
    reg [DEPTH-1:0]  used_q;
    reg              primed_q = 1'b0;

    // contents survive later resets like a non-volatile store; only the first reset clears them
    always @(posedge i_clk) begin
        if (i_reset)
            primed_q <= 1'b1;
    end

    genvar n;
    generate
        for (n = 0; n < DEPTH; n = n + 1) begin : g_slot
            always @(posedge i_clk) begin
                if (i_reset && !primed_q) begin
                    cfg_q[n]  <= `DEF_CFG;
                    name_q[n] <= {NAME_W{1'b0}};
                    used_q[n] <= 1'b0;
                end else if (i_wr_en && i_wr_idx == n) begin
                    cfg_q[n]  <= i_wr_cfg;
                    name_q[n] <= i_wr_name;
                    used_q[n] <= 1'b1;
                end
            end
        end
    endgenerate

    assign o_rd_cfg  = cfg_q[i_rd_idx];
    assign o_rd_name = name_q[i_rd_idx];
    assign o_rd_used = used_q[i_rd_idx];
endmodule // preset_store

//--- core/strap_sampler.v
// strap pin synchroniser and one-shot power-up capture
`timescale 1ns/100ps
`include "preset_consts.vh"
module strap_sampler #(
    parameter PIN_BITS = `DEF_PIN_BITS,
    parameter PIN_MAP  = `DEF_PIN_MAP
) (
    input  wire       i_clk,
    input  wire       i_reset,
    input  wire [5:0] i_pins,
    output reg  [3:0] o_sel,
    output reg        o_done
);
    localparam [7:0] SETTLE = `PIN_SETTLE_CYC;

    reg  [5:0] meta_q;
    reg  [5:0] sync_q;
    reg  [7:0] cnt_q;
    wire [3:0] bits;

    // ==================================================================
    // map candidate pins to selection bits
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_bit
            if (k < PIN_BITS) begin : g_used
                assign bits[k] = ~sync_q[PIN_MAP[3*k+2:3*k]];
            end else begin : g_unused
                assign bits[k] = 1'b0;
            end
        end
    endgenerate

    // ==================================================================
    // capture once after the pins have settled
    always @(posedge i_clk) begin
        meta_q <= i_pins;
        sync_q <= meta_q;
        if (i_reset) begin
            cnt_q  <= 8'h00;
            o_sel  <= 4'h0;
            o_done <= 1'b0;
        end else if (!o_done) begin
            if (cnt_q == SETTLE) begin
                o_sel  <= bits;
                o_done <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule // strap_sampler

//--- sim/preset_loader_assertions.sv
// concurrent checks on the preset loader ports
`timescale 1ns/100ps
`include "preset_consts.vh"
module preset_loader_assertions #(
    parameter PIN_MAP = `DEF_PIN_MAP
) (
    input wire               I_CLK_SYS,
    input wire               I_RESET,
    input wire               I_CMD_VALID,
    input wire [3:0]         I_CMD_CODE,
    input wire               I_CMD_HAS_ARG,
    input wire [`FREQ_W-1:0] I_CMD_ARG,
    input wire               O_CMD_READY,
    input wire               O_RUN,
    input wire [3:0]         O_SELECTION,
    input wire [1:0]         O_CHAN_SEL,
    input wire [`FREQ_W-1:0] O_FREQ_CH1,
    input wire [`FREQ_W-1:0] O_FREQ_CH2,
    input wire [3:0]         O_MOD_CH1,
    input wire [3:0]         O_MOD_CH2,
    input wire               O_STC,
    input wire               O_RSP_VALID,
    input wire [2:0]         O_RSP_KIND,
    input wire [3:0]         O_RSP_INDEX,
    input wire [2:0]         O_RSP_PIN,
    input wire               O_RSP_LAST
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);
    wire take   = I_CMD_VALID && O_CMD_READY;
    wire arg_ok = I_CMD_HAS_ARG && I_CMD_ARG >= 16'h0001 && I_CMD_ARG <= 16'h000f;
    // ==========================================
    // assertions
    AST_SEL_HELD: assert property (O_RUN |=> $stable(O_SELECTION))
        else $error("selection moved while running");
    AST_NO_EARLY_CMD: assert property (!O_RUN |-> !O_CMD_READY)
        else $error("commands accepted before the configuration is loaded");
    AST_STC_FOLLOWS: assert property (O_STC ==
        $past(O_MOD_CH1 == `MOD_SOQPSK_STC && O_MOD_CH2 == `MOD_SOQPSK_STC))
        else $error("space-time flag does not follow the modulations");
    AST_MOD_BOTH: assert property (take && I_CMD_CODE == `CMD_MOD && arg_ok &&
        O_CHAN_SEL == `CHAN_BOTH |=> O_MOD_CH1 == $past(I_CMD_ARG[3:0]) &&
        O_MOD_CH2 == $past(I_CMD_ARG[3:0]))
        else $error("modulation not applied to both channels");
    AST_FREQ_ONE: assert property (take && I_CMD_CODE == `CMD_FREQ && I_CMD_HAS_ARG &&
        O_CHAN_SEL == `CHAN_ONE && !O_STC |=> O_FREQ_CH1 == $past(I_CMD_ARG) &&
        $stable(O_FREQ_CH2))
        else $error("frequency not set on channel one alone");
    AST_SAVE_ACK: assert property (take && I_CMD_CODE == `CMD_SAVE && arg_ok |=>
        O_RSP_VALID && O_RSP_KIND == `RSP_SAVED && O_RSP_LAST &&
        O_RSP_INDEX == $past(I_CMD_ARG[3:0]))
        else $error("save not answered with its slot number");
    AST_SAVE_STATE: assert property (take && I_CMD_CODE == `CMD_SAVE && !I_CMD_HAS_ARG
        |=> !O_CMD_READY ##1 (O_RSP_VALID && O_RSP_KIND == `RSP_STATE && O_RSP_INDEX == 4'h1))
        else $error("bare save does not start the slot report");
    AST_LIST_ONE: assert property (take && I_CMD_CODE == `CMD_LIST && arg_ok |=>
        !O_CMD_READY ##1 (O_RSP_VALID && O_RSP_KIND == `RSP_SETTINGS && O_RSP_LAST))
        else $error("numbered list does not return one settings word");
    AST_PIN_MAP: assert property (take && I_CMD_CODE == `CMD_PINMAP |-> ##2
        (O_RSP_VALID && O_RSP_INDEX == 4'h0 && O_RSP_PIN == PIN_MAP[2:0]) ##1
        (O_RSP_VALID && O_RSP_INDEX == 4'h1 && O_RSP_PIN == PIN_MAP[5:3]))
        else $error("pin map report out of order");
    COV_PRESET_BOOT: cover property ($rose(O_RUN) && O_SELECTION != 4'h0);
    COV_STC_ON: cover property ($rose(O_STC));
    COV_NAME_LIST: cover property (O_RSP_LAST && O_RSP_KIND == `RSP_NAME);
endmodule // preset_loader_assertions

//--- sim/strap_switches.sv
// strap switch bank model driving the candidate preset pins
`timescale 1ns/100ps
module strap_switches (
    input  wire [5:0] i_ground,
    output wire [5:0] o_pin
);
    assign o_pin = ~i_ground;
endmodule // strap_switches

//--- sim/testbench.sv
// self-checking bench for the power-up preset loader
`timescale 1ns/100ps
`include "preset_consts.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    localparam logic [11:0] PMAP  = `DEF_PIN_MAP;
    localparam logic [31:0] NAME  = 32'h5e7a_0005;
    // f1 2000, f2 3000, modulation 1 on both, randomizer and diff-enc on
    localparam logic [44:0] SAVED = {3'h5, 2'h0, 4'h1, 4'h1, 16'h3000, 16'h2000};
    logic        I_CLK_SYS = 1'b0;
    logic        I_RESET = 1'b1;
    logic        I_CMD_VALID = 1'b0;
    logic        I_CMD_HAS_ARG = 1'b0;
    logic [3:0]  I_CMD_CODE = 4'h0;
    logic [15:0] I_CMD_ARG = 16'h0;
    logic [31:0] I_CMD_NAME = 32'h0;
    logic [5:0]  gnd = 6'h00;
    wire  [5:0]  I_PRESET_PIN;
    wire         O_CMD_READY, O_RUN, O_STC, O_RSP_VALID, O_RSP_USED, O_RSP_LAST;
    wire         O_LDPC_CH1, O_LDPC_CH2, O_RANDOMIZER, O_INVERT, O_DIFF_ENC;
    wire  [1:0]  O_CHAN_SEL;
    wire  [2:0]  O_RSP_KIND, O_RSP_PIN;
    wire  [3:0]  O_SELECTION, O_MOD_CH1, O_MOD_CH2, O_RSP_INDEX;
    wire  [15:0] O_FREQ_CH1, O_FREQ_CH2;
    wire  [31:0] O_RSP_NAME;
    wire  [44:0] O_RSP_CONFIG;
    wire  [44:0] live = {O_DIFF_ENC, O_INVERT, O_RANDOMIZER, O_LDPC_CH2, O_LDPC_CH1,
                         O_MOD_CH2, O_MOD_CH1, O_FREQ_CH2, O_FREQ_CH1};
    logic [2:0]  rk [16], rp [16];
    logic [3:0]  ri [16];
    logic        ru [16];
    logic [31:0] rn [16];
    logic [44:0] rc [16];
    int          nr, k, n_fail = 0, cmp_count = 0;
    always #5 I_CLK_SYS = ~I_CLK_SYS;
    power_up_preset_loader i_dut (.*);
    strap_switches i_sw (.i_ground(gnd), .o_pin(I_PRESET_PIN));
    // ==========================================
    // access tasks
    task stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task hang;
        `CHK(1'b0, 1'b1)
        stop_test;
    endtask
    task boot(input logic [5:0] g);
        int i;
        @(posedge I_CLK_SYS);
        I_RESET <= 1'b1;
        gnd <= g;
        repeat (12) @(posedge I_CLK_SYS);
        I_RESET <= 1'b0;
        for (i = 0; O_RUN !== 1'b1; i++) begin
            if (i > 80) hang;
            @(posedge I_CLK_SYS) #1;
        end
    endtask
    task cmd(input logic [3:0] c, input logic h, input logic [15:0] a,
             input logic [31:0] n = 32'h0);
        int i;
        nr = 0;
        for (i = 0; O_CMD_READY !== 1'b1; i++) begin
            if (i > 40) hang;
            @(posedge I_CLK_SYS) #1;
        end
        @(posedge I_CLK_SYS);
        I_CMD_VALID   <= 1'b1;
        I_CMD_CODE    <= c;
        I_CMD_HAS_ARG <= h;
        I_CMD_ARG     <= a;
        I_CMD_NAME    <= n;
        @(posedge I_CLK_SYS);
        I_CMD_VALID <= 1'b0;
        for (i = 0; i < 40; i++) begin
            #1;
            if (O_RSP_VALID === 1'b1) begin
                rk[nr] = O_RSP_KIND;
                ri[nr] = O_RSP_INDEX;
                ru[nr] = O_RSP_USED;
                rn[nr] = O_RSP_NAME;
                rc[nr] = O_RSP_CONFIG;
                rp[nr] = O_RSP_PIN;
                nr++;
                if (O_RSP_LAST === 1'b1) break;
            end
            @(posedge I_CLK_SYS);
        end
        if (i == 40) hang;
    endtask
    // ==========================================
    // main sequence
    initial begin
        boot(6'h00);
        `CHK(O_SELECTION, 4'h0)
        `CHK({O_FREQ_CH1, O_MOD_CH1, O_CHAN_SEL}, {`DEF_FREQ, `DEF_MOD, `CHAN_ONE})
        cmd(`CMD_CHAN, 1'b1, 16'h3);
        cmd(`CMD_MOD, 1'b1, 16'hd);
        cmd(`CMD_LDPC, 1'b1, 16'h1);
        cmd(`CMD_FREQ, 1'b1, 16'h1234);
        `CHK({O_MOD_CH1, O_MOD_CH2, O_LDPC_CH1, O_LDPC_CH2}, {8'hdd, 2'h3})
        `CHK({O_STC, O_FREQ_CH1, O_FREQ_CH2}, {1'b1, 32'h1234_1234})
        cmd(`CMD_MOD, 1'b1, 16'h1);
        cmd(`CMD_LDPC, 1'b1, 16'h0);
        cmd(`CMD_CHAN, 1'b1, 16'h1);
        `CHK({O_STC, O_MOD_CH1, O_MOD_CH2, O_LDPC_CH1, O_LDPC_CH2}, {1'b0, 8'h11, 2'h0})
        cmd(`CMD_FREQ, 1'b1, 16'h2000);
        cmd(`CMD_CHAN, 1'b1, 16'h2);
        cmd(`CMD_FREQ, 1'b1, 16'h3000);
        cmd(`CMD_FLAGS, 1'b1, 16'h5);
        `CHK({rk[0], O_RANDOMIZER, O_INVERT, O_DIFF_ENC}, {`RSP_ACK, 3'h5})
        `CHK({O_FREQ_CH1, O_FREQ_CH2}, 32'h2000_3000)
        cmd(`CMD_SAVE, 1'b1, 16'h5, NAME);
        `CHK({nr[3:0], rk[0], ri[0]}, {4'h1, `RSP_SAVED, 4'h5})
        for (k = 0; k < 32; k += 16) begin
            cmd(`CMD_SAVE, 1'b1, k[15:0]);
            `CHK(rk[0], `RSP_ERR)
        end
        cmd(4'hf, 1'b0, 16'h0);
        `CHK(rk[0], `RSP_ERR)
        cmd(`CMD_CHAN, 1'b1, 16'h4);
        `CHK({rk[0], O_CHAN_SEL}, {`RSP_ERR, `CHAN_TWO})
        cmd(`CMD_SAVE, 1'b0, 16'h0);
        `CHK(nr, 15)
        for (k = 1; k < 16; k++)
            `CHK({rk[k-1], ri[k-1], ru[k-1]}, {`RSP_STATE, k[3:0], k == 5})
        cmd(`CMD_LIST, 1'b0, 16'h0);
        for (k = 1; k < 16; k++)
            `CHK({rk[k-1], ri[k-1]}, {`RSP_NAME, k[3:0]})
        `CHK(rn[4], NAME)
        cmd(`CMD_LIST, 1'b1, 16'h5);
        `CHK({rk[0], ri[0], rc[0]}, {`RSP_SETTINGS, 4'h5, SAVED})
        cmd(`CMD_PINMAP, 1'b0, 16'h0);
        `CHK(nr, `DEF_PIN_BITS)
        for (k = 0; k < `DEF_PIN_BITS; k++)
            `CHK({rk[k], ri[k], rp[k]}, {`RSP_PINMAP, k[3:0], PMAP[3*k+:3]})
        boot(6'h05);
        `CHK(O_SELECTION, 4'h5)
        `CHK(live, SAVED)
        @(posedge I_CLK_SYS);
        gnd <= 6'h3a;
        repeat (30) @(posedge I_CLK_SYS);
        #1;
        `CHK({O_SELECTION, live}, {4'h5, SAVED})
        stop_test;
    end
endmodule // testbench
bind power_up_preset_loader preset_loader_assertions #(.PIN_MAP(PIN_MAP)) i_chk (.*);
